/* File: src/sdg_pkg.sv */
// Shared constants of the step generator and diagnostics block.
// Assumes a 32-bit APB master and a single system clock.
package sdg_pkg;
	// Widths
	localparam int VEL_W = 24; // Signed velocity, full phase accumulator
	localparam int MS_W = 10; // Microstep counter, 1024 table entries
	localparam int TINT_W = 20; // Step interval counter
	localparam int ADDR_W = 8; // APB byte address width
	localparam int NSYNC = 11; // Pin inputs passing the synchroniser
	// Register byte offsets
	localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h00;
	localparam logic [7:0] OFS_INTERNAL_VELOCITY = 8'h04;
	localparam logic [7:0] OFS_STEP_INTERVAL = 8'h08;
	localparam logic [7:0] OFS_MICROSTEP_COUNTER = 8'h0C;
	localparam logic [7:0] OFS_DRIVER_STATE = 8'h10;
	localparam logic [7:0] OFS_ENERGY_THRESHOLD = 8'h14;
	// Global config fields
	localparam int CFG_ENABLE = 0;
	localparam int CFG_DIAG_STEP = 1;
	localparam int CFG_DIAG_INDEX = 2;
	localparam int CFG_DIAG_ERROR = 3;
	localparam logic [3:0] CFG_RESET = 4'h8;
	// Driver state word fields
	localparam int ST_OTPW = 0;
	localparam int ST_OT = 1;
	localparam int ST_SHORT = 2; // Four bits: gnd A, gnd B, supply A, supply B
	localparam int ST_OLA = 6;
	localparam int ST_OLB = 7;
	localparam int ST_UV = 8;
	localparam int ST_BRIDGE = 9;
	localparam int ST_SLOW = 10;
	// Other reset values and counts
	localparam logic [VEL_W-1:0] VEL_RESET = 24'h000000;
	localparam logic [TINT_W-1:0] THR_RESET = 20'h00000;
	localparam logic [1:0] SHORT_RETRIES = 2'h3;
endpackage

/* File: src/sdg_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
module sdg_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q; // First stage, read only by the second

	// Two stages; only the second is visible to logic
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

/* File: src/sdg_short_filter.sv */
// Short detection filter: one detection plus the retries must agree.
// Assumes a synchronised comparator level on the input.
`timescale 1ns/1ps
module sdg_short_filter #(
	parameter logic [1:0] RETRIES = sdg_pkg::SHORT_RETRIES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic detect,
	output logic confirm
);
	logic [1:0] cnt_q; // Retries already agreeing
	logic [1:0] cnt_d;

	// A gap in detection restarts the count, so a lone ESD glitch is dropped
	assign cnt_d = !detect ? 2'h0 : (cnt_q == RETRIES) ? cnt_q : cnt_q + 2'h1;
	assign confirm = detect && (cnt_q == RETRIES);

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 2'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	a_retry_three_agree: assert property (@(posedge clk) disable iff (rst)
		confirm |-> $past(detect, 1) && $past(detect, 2) && $past(detect, 3))
		else $error("short confirmed without three retries");
endmodule

/* File: src/sdg_top.sv */
// Step pulse generator, protection flags and diagnostic pin, behind APB.
// Assumes comparator levels and STEP/DIR from pins, all asynchronous.
// How it works
// - Microstep rate is velocity times clock over 2^24
// - Velocity takes effect at once, no ramp
// - Interval counts clocks between consecutive microsteps
// - Step mode toggles diagnostic pin each microstep
// - Microstep counter wraps modulo 1024
// - Pre-warning and shutdown temperature flags
// - After shutdown, bridges off until pre-warning clears
// - Short confirmed only after three retries
// - Confirmed short kills bridges, sets phase flag
// - Short latch cleared only by disable, re-enable
// - Open-load flags are status only
// - Error mode raises pin on temperature shutdown, short or undervoltage
// - Index mode marks microstep counter zero
// - Config bits select the diagnostic pin source
// - State word shows shorts, undervoltage, open load
// - Counter indexes 1024-entry table, four fullsteps
// - Index active once per electrical period
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module sdg_top (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [sdg_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic STEP_IN,
	input wire logic DIR_IN,
	input wire logic TEMP_WARN_IN,
	input wire logic TEMP_SHUT_IN,
	input wire logic SHORT_GND_A_IN,
	input wire logic SHORT_GND_B_IN,
	input wire logic SHORT_SUP_A_IN,
	input wire logic SHORT_SUP_B_IN,
	input wire logic OPEN_LOAD_A_IN,
	input wire logic OPEN_LOAD_B_IN,
	input wire logic UNDERVOLT_IN,
	output logic BRIDGE_EN,
	output logic DIAG_OUT
);
	localparam int VW = sdg_pkg::VEL_W;
	localparam int MW = sdg_pkg::MS_W;
	localparam int TW = sdg_pkg::TINT_W;
	localparam logic [TW-1:0] TMAX = '1; // Interval saturates here

	// Synchronised pin levels
	logic [sdg_pkg::NSYNC-1:0] pins_s;
	logic step_s, dir_s, warn_s, shut_s, uv_s, ola_s, olb_s;
	logic [3:0] short_s; // Bit 0 gnd A, 1 gnd B, 2 supply A, 3 supply B
	logic [3:0] confirm; // Filtered short confirmations

	// Registers
	logic [3:0] cfg_q; // global_config
	logic [VW-1:0] vel_q; // internal_velocity
	logic [TW-1:0] thr_q; // energy_save_velocity_threshold
	logic [VW-1:0] acc_q; // Phase accumulator
	logic [MW-1:0] ms_q, ms_d; // microstep_counter
	logic [TW-1:0] tcnt_q; // Clocks since last microstep
	logic [TW-1:0] tint_q; // step_interval_clocks
	logic step_prev_q; // STEP level one cycle ago
	logic tog_q; // Step indication toggle
	logic en_prev_q; // Enable bit one cycle ago
	logic ot_hold_q, ot_hold_d; // overtemp_shutdown_flag
	logic otpw_q; // Pre-warning flag
	logic [3:0] short_q, short_d; // Latched short flags
	logic ola_q, olb_q, uv_q; // Live status flags
	logic diag_q; // Diagnostic pin register
	logic bridge_q, bridge_d;
	logic [31:0] rdata_q;

	// Step generator wires
	logic vel_neg, vel_zero, int_step, ext_step, ustep, dir_down;
	logic [VW-1:0] vel_mag;
	logic [VW:0] acc_sum;
	logic [TW-1:0] tcnt_inc;

	// Bus decode wires
	logic setup, wr_en, hit;
	logic sel_cfg, sel_vel, sel_tint, sel_ms, sel_st, sel_thr;
	logic [31:0] rd_mux, state_word;

	// Protection and diag wires
	logic en, en_rise, fault, diag_d;
	logic index_hit, slow;

	// Pin inputs pass two flops before any logic
	sdg_sync #(.W(sdg_pkg::NSYNC)) u_sync (
		.clk(CLK_SYS),
		.rst(RESET),
		.din({STEP_IN, DIR_IN, TEMP_WARN_IN, TEMP_SHUT_IN, SHORT_GND_A_IN,
			SHORT_GND_B_IN, SHORT_SUP_A_IN, SHORT_SUP_B_IN,
			OPEN_LOAD_A_IN, OPEN_LOAD_B_IN, UNDERVOLT_IN}),
		.dout(pins_s)
	);
	assign step_s = pins_s[10];
	assign dir_s = pins_s[9];
	assign warn_s = pins_s[8];
	assign shut_s = pins_s[7];
	// Reversed so that bit 0 (gnd A) lands on the lowest short bit of the state word
	assign short_s = {pins_s[3], pins_s[4], pins_s[5], pins_s[6]};
	assign ola_s = pins_s[2];
	assign olb_s = pins_s[1];
	assign uv_s = pins_s[0];

	// One filter per short comparator
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_short
			sdg_short_filter u_filt (
				.clk(CLK_SYS),
				.rst(RESET),
				.detect(short_s[gi]),
				.confirm(confirm[gi])
			);
		end
	endgenerate

	// APB decode; zero wait states, unmapped addresses answer with an error
	assign setup = PSEL && !PENABLE;
	assign sel_cfg = PADDR == sdg_pkg::OFS_GLOBAL_CONFIG;
	assign sel_vel = PADDR == sdg_pkg::OFS_INTERNAL_VELOCITY;
	assign sel_tint = PADDR == sdg_pkg::OFS_STEP_INTERVAL;
	assign sel_ms = PADDR == sdg_pkg::OFS_MICROSTEP_COUNTER;
	assign sel_st = PADDR == sdg_pkg::OFS_DRIVER_STATE;
	assign sel_thr = PADDR == sdg_pkg::OFS_ENERGY_THRESHOLD;
	assign hit = sel_cfg | sel_vel | sel_tint | sel_ms | sel_st | sel_thr;
	assign wr_en = PSEL && PENABLE && PWRITE && hit;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit;
	assign PRDATA = rdata_q;

	// Driver status word, reserved bits read zero
	assign state_word = {21'h000000, slow, bridge_q, uv_q, olb_q, ola_q,
		short_q, ot_hold_q, otpw_q};
	assign rd_mux = sel_cfg ? {28'h0000000, cfg_q} :
		sel_vel ? {8'h00, vel_q} :
		sel_tint ? {12'h000, tint_q} :
		sel_ms ? {22'h000000, ms_q} :
		sel_st ? state_word :
		sel_thr ? {12'h000, thr_q} : 32'h00000000;

	// Configuration registers; writes to read-only words are dropped
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			cfg_q <= sdg_pkg::CFG_RESET;
			vel_q <= sdg_pkg::VEL_RESET;
			thr_q <= sdg_pkg::THR_RESET;
		end else if (wr_en) begin
			if (sel_cfg) begin
				cfg_q <= PWDATA[3:0];
			end
			if (sel_vel) begin
				vel_q <= PWDATA[VW-1:0];
			end
			if (sel_thr) begin
				thr_q <= PWDATA[TW-1:0];
			end
		end
	end

	// Read data is captured in the setup cycle so PRDATA is a flop
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			rdata_q <= 32'h00000000;
		end else if (setup && !PWRITE) begin
			rdata_q <= rd_mux;
		end
	end

	// Velocity is signed; its magnitude feeds a 2^24 phase accumulator
	assign vel_neg = vel_q[VW-1];
	assign vel_zero = vel_q == '0;
	assign vel_mag = vel_neg ? VW'(-vel_q) : vel_q;
	assign acc_sum = {1'b0, acc_q} + {1'b0, vel_mag};
	assign int_step = acc_sum[VW];
	// The step pin only moves the motor while the internal generator rests
	assign ext_step = vel_zero && step_s && !step_prev_q;
	assign ustep = int_step || ext_step;
	assign dir_down = vel_zero ? dir_s : vel_neg;
	// Natural 10-bit wrap gives 1023 -> 0 and back, four fullsteps a lap
	assign ms_d = dir_down ? ms_q - MW'(1) : ms_q + MW'(1);
	assign tcnt_inc = (tcnt_q == TMAX) ? TMAX : tcnt_q + TW'(1);

	// Accumulator and counter: velocity acts from the next clock, no ramp
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			acc_q <= '0;
			ms_q <= '0;
			step_prev_q <= 1'b0;
			tog_q <= 1'b0;
		end else begin
			acc_q <= acc_sum[VW-1:0];
			step_prev_q <= step_s;
			if (ustep) begin
				ms_q <= ms_d;
				tog_q <= !tog_q;
			end
		end
	end

	// Interval between microsteps from either source, saturating at standstill
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			tcnt_q <= '0;
			tint_q <= TMAX;
		end else if (ustep) begin
			tcnt_q <= '0;
			tint_q <= tcnt_inc;
		end else begin
			tcnt_q <= tcnt_inc;
			if (tcnt_q == TMAX) begin
				tint_q <= TMAX;
			end
		end
	end
	// A long interval means slow motion, below the energy-save threshold
	assign slow = tint_q >= thr_q;

	// Protection: temperature hysteresis and short latches
	assign en = cfg_q[sdg_pkg::CFG_ENABLE];
	assign en_rise = en && !en_prev_q;
	// Shutdown is held until the pre-warning level is left; set wins
	assign ot_hold_d = shut_s || (ot_hold_q && warn_s);
	// New confirmations win over the re-enable clear
	assign short_d = (en_rise ? 4'h0 : short_q) | confirm;
	// Open load never enters the bridge enable; pre-warning only through the shutdown hold
	assign bridge_d = en && !ot_hold_d && (short_d == 4'h0) && !uv_s;
	assign fault = ot_hold_q || (short_q != 4'h0) || uv_q;

	// Flag registers, cleared at reset
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			en_prev_q <= 1'b0;
			ot_hold_q <= 1'b0;
			otpw_q <= 1'b0;
			short_q <= 4'h0;
			ola_q <= 1'b0;
			olb_q <= 1'b0;
			uv_q <= 1'b0;
			bridge_q <= 1'b0;
		end else begin
			en_prev_q <= en;
			ot_hold_q <= ot_hold_d;
			otpw_q <= warn_s;
			short_q <= short_d;
			ola_q <= ola_s;
			olb_q <= olb_s;
			uv_q <= uv_s;
			bridge_q <= bridge_d;
		end
	end
	assign BRIDGE_EN = bridge_q;

	// Diagnostic pin: OR of the selected sources
	assign index_hit = ms_q == '0;
	assign diag_d = (cfg_q[sdg_pkg::CFG_DIAG_ERROR] && fault) ||
		(cfg_q[sdg_pkg::CFG_DIAG_INDEX] && index_hit) ||
		(cfg_q[sdg_pkg::CFG_DIAG_STEP] && tog_q);
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			diag_q <= 1'b0;
		end else begin
			diag_q <= diag_d;
		end
	end
	assign DIAG_OUT = diag_q;

	// Checks
	a_short_kills_bridge: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(confirm != 4'h0) |=> !BRIDGE_EN [*2])
		else $error("bridge on after confirmed short");
	a_short_needs_reenable: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(short_q != 4'h0) && !en_rise |=> (short_q != 4'h0))
		else $error("short flag lost without re-enable");
	a_ot_hysteresis: assert property (@(posedge CLK_SYS) disable iff (RESET)
		ot_hold_q && warn_s |=> ot_hold_q && !BRIDGE_EN)
		else $error("bridge restarted above pre-warning");
	a_counter_wraps: assert property (@(posedge CLK_SYS) disable iff (RESET)
		ustep && !dir_down && ms_q == 10'h3FF |=> ms_q == 10'h000)
		else $error("microstep counter did not wrap");
	a_interval_capture: assert property (@(posedge CLK_SYS) disable iff (RESET)
		ustep && tcnt_q < TMAX |=> tint_q == $past(tcnt_q) + TW'(1))
		else $error("step interval wrong");
	a_zero_vel_still: assert property (@(posedge CLK_SYS) disable iff (RESET)
		vel_zero && !(step_s && !step_prev_q) |=> $stable(ms_q))
		else $error("counter moved at zero velocity");
	a_step_toggles_diag: assert property (@(posedge CLK_SYS) disable iff (RESET)
		cfg_q[3:1] == 3'h1 && ustep ##1 cfg_q[3:1] == 3'h1 |=> DIAG_OUT != $past(DIAG_OUT))
		else $error("diag did not toggle on microstep");
	a_index_marks_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
		cfg_q[sdg_pkg::CFG_DIAG_INDEX] && ms_q == 10'h000 |=> DIAG_OUT)
		else $error("index not shown at counter zero");
	a_error_on_diag: assert property (@(posedge CLK_SYS) disable iff (RESET)
		cfg_q[sdg_pkg::CFG_DIAG_ERROR] && fault |=> DIAG_OUT)
		else $error("fault not shown on diag");
	a_open_load_inert: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(ola_s || olb_s) && en && !ot_hold_d && (short_d == 4'h0) && !uv_s |=> BRIDGE_EN)
		else $error("open load changed bridge state");
	a_rate_carry: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(vel_q == 24'h400000) [*5] |-> int_step == $past(int_step, 4))
		else $error("quarter rate step period not four clocks");

	c_short_event: cover property (@(posedge CLK_SYS) disable iff (RESET) confirm != 4'h0);
	c_wrap_down: cover property (@(posedge CLK_SYS) disable iff (RESET)
		ustep && dir_down && ms_q == 10'h000);
	c_ot_release: cover property (@(posedge CLK_SYS) disable iff (RESET)
		ot_hold_q ##1 !ot_hold_q);
	c_reenable: cover property (@(posedge CLK_SYS) disable iff (RESET)
		en_rise && short_q != 4'h0);
endmodule

/* File: dv/sdg_host_model.sv */
// APB host model: master cycles and the host's own velocity habits.
// Assumes one clock and a slave that answers through pready.
`timescale 1ns/1ps
module sdg_host_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [sdg_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Bus idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end
	// One full transfer; holds everything until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench's hang guard ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Register write, response ignored
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
	endtask
	// Register read with error flag
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic e);
		xfer(1'b0, a, 32'h00000000, d, e);
	endtask
	// Speed up in small increments; the block itself never ramps
	task automatic ramp(input logic [23:0] target, input logic [23:0] inc);
		logic [23:0] v;
		v = 24'h000000;
		while (v < target) begin
			v = v + inc;
			wr(8'h04, {8'h00, v});
		end
	endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the step generator and diagnostics block.
// Assumes the APB host model and a 40 MHz system clock.
`timescale 1ns/1ps
module testbench;
	logic clk, rst, psel, pen, pwr, prdy, perr, step, dir, tw, ts, ola, olb, uv, ben, diag;
	logic [7:0] paddr;
	logic [31:0] pwd, prd, d;
	logic [3:0] sh;
	logic e;
	int failures, checks_done, cyc, c;
	// Reset expectations, one entry per register
	logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	logic [31:0] rx [6] = '{32'h8, 32'h0, 32'hFFFFF, 32'h0, 32'h400, 32'h0};
	sdg_top sdg_top_inst (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
		.PSLVERR(perr), .STEP_IN(step), .DIR_IN(dir), .TEMP_WARN_IN(tw),
		.TEMP_SHUT_IN(ts), .SHORT_GND_A_IN(sh[0]), .SHORT_GND_B_IN(sh[1]),
		.SHORT_SUP_A_IN(sh[2]), .SHORT_SUP_B_IN(sh[3]), .OPEN_LOAD_A_IN(ola),
		.OPEN_LOAD_B_IN(olb), .UNDERVOLT_IN(uv), .BRIDGE_EN(ben), .DIAG_OUT(diag));
	sdg_host_model sdg_host_model_inst (.clk(clk), .psel(psel), .penable(pen),
		.pwrite(pwr), .paddr(paddr), .pwdata(pwd), .prdata(prd), .pready(prdy),
		.pslverr(perr));
	// Clock, 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, x, g);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		sdg_host_model_inst.rd(a, d, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		sdg_host_model_inst.wr(a, v);
	endtask
	// Counter advance over exactly s cycles between read setup edges
	task automatic meas(input logic [23:0] v, input int s, input logic [9:0] dx);
		logic [9:0] a;
		wr(8'h04, {8'h00, v});
		rd(8'h0C);
		a = d[9:0];
		cy(s - 3);
		rd(8'h0C);
		chk("counter advance", {22'h0, dx}, {22'h0, d[9:0] - a});
	endtask
	// Count changes (or rises only) of the diagnostic pin
	task automatic edges(input int n, input logic rise);
		logic p;
		c = 0;
		#1 p = diag;
		repeat (n) begin
			@(posedge clk);
			#1 if (diag !== p && (!rise || diag)) c++;
			p = diag;
		end
	endtask
	task automatic pulse();
		step <= 1'b1;
		cy(4);
		step <= 1'b0;
		cy(4);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 50000) begin
			failures++;
			summarize();
		end
	end
	// Main sequence
	initial begin
		{rst, step, dir, tw, ts, ola, olb, uv} = 8'h80;
		sh = 4'h0;
		failures = 0;
		checks_done = 0;
		cyc = 0;
		cy(8);
		rst <= 1'b0;
		#1 chk("bridge at reset", 32'h0, {31'h0, ben});
		for (int i = 0; i < 6; i++) begin
			rd(ra[i]);
			chk("reset value", rx[i], d);
		end
		rd(8'h20);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, d);
		wr(8'h0C, 32'h3FF);
		rd(8'h0C);
		chk("read-only counter", 32'h0, d);
		wr(8'h14, 32'h12345);
		rd(8'h14);
		chk("threshold", 32'h12345, d);
		$display("test registers done");
		wr(8'h00, 32'h9);
		sdg_host_model_inst.ramp(24'h400000, 24'h100000);
		meas(24'h400000, 400, 10'd100);
		rd(8'h08);
		chk("interval", 32'h4, d);
		meas(24'h400000, 4400, 10'd76);
		meas(24'hC00000, 400, 10'd924);
		$display("test velocity done");
		wr(8'h04, 32'h400000);
		wr(8'h00, 32'h3);
		cy(1);
		edges(400, 1'b0);
		chk("step toggles", 32'd100, c);
		wr(8'h00, 32'h5);
		cy(1);
		edges(4096, 1'b1);
		chk("index marks", 32'd1, c);
		$display("test diag done");
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h1);
		rd(8'h0C);
		c = d[9:0];
		repeat (5) pulse();
		dir <= 1'b1;
		cy(2);
		repeat (3) pulse();
		cy(6);
		rd(8'h0C);
		chk("step pin count", 32'd2, {22'h0, d[9:0] - c[9:0]});
		$display("test step pin done");
		wr(8'h00, 32'h9);
		tw <= 1'b1;
		cy(6);
		#1 chk("bridge prewarn", 32'h1, {31'h0, ben});
		cy(1);
		ts <= 1'b1;
		cy(6);
		#1 chk("bridge hot", 32'h0, {31'h0, ben});
		chk("diag hot", 32'h1, {31'h0, diag});
		rd(8'h10);
		chk("temp flags", 32'h3, {30'h0, d[1:0]});
		ts <= 1'b0;
		cy(6);
		#1 chk("bridge cooling", 32'h0, {31'h0, ben});
		cy(1);
		tw <= 1'b0;
		cy(6);
		#1 chk("bridge cool", 32'h1, {31'h0, ben});
		$display("test temperature done");
		for (int i = 0; i < 4; i++) begin
			cy(1);
			sh <= 4'h1 << i;
			cy(3);
			sh <= 4'h0;
			cy(6);
			#1 chk("short glitch", 32'h1, {31'h0, ben});
			cy(1);
			sh <= 4'h1 << i;
			cy(6);
			sh <= 4'h0;
			cy(4);
			#1 chk("short off", 32'h0, {31'h0, ben});
			chk("diag short", 32'h1, {31'h0, diag});
			rd(8'h10);
			chk("short flag", 32'h1 << i, {28'h0, d[5:2]});
			wr(8'h00, 32'h8);
			wr(8'h00, 32'h9);
			cy(4);
			#1 chk("restart", 32'h1, {31'h0, ben});
			rd(8'h10);
			chk("short cleared", 32'h0, {28'h0, d[5:2]});
		end
		$display("test shorts done");
		// Open-load flags read at standstill only
		ola <= 1'b1;
		olb <= 1'b1;
		cy(6);
		#1 chk("bridge open load", 32'h1, {31'h0, ben});
		rd(8'h10);
		chk("open load", 32'h3, {30'h0, d[7:6]});
		uv <= 1'b1;
		cy(6);
		#1 chk("bridge undervolt", 32'h0, {31'h0, ben});
		rd(8'h10);
		chk("undervolt flag", 32'h1, {31'h0, d[8]});
		{uv, ola, olb} <= 3'h0;
		cy(6);
		#1 chk("bridge recovered", 32'h1, {31'h0, ben});
		$display("test status done");
		summarize();
	end
endmodule
